// ---- inc/led_sup_pkg.sv ----
// shared constants and carrier types for the led fault supervisor
`default_nettype none
package led_sup_pkg;
  localparam int unsigned CLK_HZ = 20_000_000;
  // times in their own units
  localparam int unsigned DIM_OFF_MS      = 28;
  localparam int unsigned ENABLE_PULSE_US = 40;
  localparam int unsigned SOFT_TOTAL_US   = 1000;
  localparam int unsigned OPEN_TO_US      = 6000;
  localparam int unsigned OPEN_HOT_TO_US  = 800;
  // cycle counts: least times round up, longest round down
  localparam int unsigned DIM_OFF_CYC     = DIM_OFF_MS * (CLK_HZ / 1000);
  localparam int unsigned ENABLE_CYC      = (ENABLE_PULSE_US * (CLK_HZ / 1000) + 999) / 1000;
  localparam int unsigned SOFT_STEPS      = 8;
  // seven rises share the soft-start time, so the last level is in force when it ends
  localparam int unsigned SOFT_STEP_CYC   =
    (SOFT_TOTAL_US * (CLK_HZ / 1000)) / 1000 / (SOFT_STEPS - 1);
  localparam int unsigned OPEN_TO_CYC     = OPEN_TO_US * (CLK_HZ / 1000) / 1000;
  localparam int unsigned OPEN_HOT_TO_CYC = OPEN_HOT_TO_US * (CLK_HZ / 1000) / 1000;
  // current limit code: 1 step = 375mA, 8 steps = 3A
  localparam logic [3:0] ILIM_FIRST = 4'h1;
  localparam logic [3:0] ILIM_FINAL = 4'h8;
  localparam int unsigned NCH = 8;

  typedef enum logic [2:0] {
    ST_OFF     = 3'b000,
    ST_WAITEN  = 3'b001,
    ST_PRECHK  = 3'b010,
    ST_INRUSH  = 3'b011,
    ST_RUN     = 3'b100,
    ST_TRIP    = 3'b101
  } phase_e;

  // per-channel analog comparator flags
  typedef struct packed {
    logic [NCH-1:0] above_75;
    logic [NCH-1:0] below_50;
    logic [NCH-1:0] above_8v;
  } chan_cmp_s;

  // global analog comparator flags
  typedef struct packed {
    logic input_undervoltage_lockout;
    logic sw_above_1v2;
    logic ovp_limit;
    logic ovp_above_20;
    logic disc_full_on;
    logic sw_over_ilim;
    logic in_overcurrent;
    logic otp_lower;
    logic stable;
  } glob_cmp_s;
endpackage
`default_nettype wire

// ---- rtl/chan_monitor.sv ----
// one led channel: good/open tracking, open timeout and short disable
`timescale 1ns/1ns
`default_nettype none
module chan_monitor #(
  parameter int unsigned TO_CYC     = led_sup_pkg::OPEN_TO_CYC,
  parameter int unsigned HOT_TO_CYC = led_sup_pkg::OPEN_HOT_TO_CYC
) (
  // clock and reset
  input  wire logic ref_clk,
  input  wire logic rst,
  // control
  input  wire logic active,
  input  wire logic stable,
  input  wire logic hot,
  input  wire logic ovp_limit,
  // comparators
  input  wire logic above_75,
  input  wire logic below_50,
  input  wire logic above_8v,
  // status
  output logic      good_r,
  output logic      open_r,
  output logic      disabled_r
);
  logic [22:0] cnt_r;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      good_r <= 1'b0;
    else if (!active)
      good_r <= 1'b0;
    else if (above_75)
      good_r <= 1'b1;

  // open classification; only the below-50% drop decision waits for stable feedback
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      open_r <= 1'b0;
    else if (!active)
      open_r <= 1'b0;
    else if (ovp_limit && !good_r)
      open_r <= 1'b1;
    else if (hot && !good_r)
      open_r <= 1'b1;
    else if (stable && good_r && below_50)
      open_r <= 1'b1;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      cnt_r <= '0;
    else if (!open_r || disabled_r)
      cnt_r <= '0;
    else
      cnt_r <= cnt_r + 23'h000001;

  // short disable; open disable after timeout
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      disabled_r <= 1'b0;
    else if (!active)
      disabled_r <= 1'b0;
    else if (stable && above_8v)
      disabled_r <= 1'b1;
    else if (open_r && (cnt_r >= 23'(hot ? HOT_TO_CYC - 1 : TO_CYC - 1)))
      disabled_r <= 1'b1;
endmodule
`default_nettype wire

// ---- rtl/led_driver_fault_supervisor.sv ----
// sequencing and fault supervision for an eight channel led driver
`timescale 1ns/1ns
`default_nettype none
// Contract
// - channel current gated by dimming input level, average tracks duty
// - dimming input low longer than 28ms forces shutdown
// - 30uA sink on disconnect gate during start-up
// - switching starts only after disconnect switch fully on
// - switch current over limit ends that switching cycle
// - soft-start limit 375mA then seven 375mA steps to 3A
// - soft-start steps spread over 1ms total
// - below-50% open and 8V short decisions suppressed while feedback not stable
// - input overcurrent fault shuts all channels down
// - channel above 8V is disabled
// - channel reaching 75% target current marked good
// - good channel falling below 50% classified open
// - ovp limit or lower overtemp makes non-good channels open
// - open channel disabled after timeout, shorter when hot
// - open timeout 6ms normally, 800us when hot
// - zener-bypassed string kept unless ovp limit reached
// - undervoltage stops switching and resets; restarts on recovery
// - start-up injects switch node current, waits for 1.2V
// - switch node low while switch off opens disconnect switch
// - ovp sense rising over then under 20% opens disconnect
// - first dimming pulse of at least 40us enables device
module led_driver_fault_supervisor #(
  parameter int unsigned NCH         = led_sup_pkg::NCH,
  parameter int unsigned DIM_OFF_CYC = led_sup_pkg::DIM_OFF_CYC,
  parameter int unsigned SOFT_STEP   = led_sup_pkg::SOFT_STEP_CYC,
  parameter int unsigned OPEN_TO     = led_sup_pkg::OPEN_TO_CYC,
  parameter int unsigned OPEN_HOT_TO = led_sup_pkg::OPEN_HOT_TO_CYC
) (
  // clock and reset
  input  wire logic                  ref_clk,
  input  wire logic                  rst,
  // dimming source
  input  wire logic                  enable_dimming_input,
  // analog comparators
  input  wire led_sup_pkg::chan_cmp_s chan_cmp,
  input  wire led_sup_pkg::glob_cmp_s glob_cmp,
  input  wire logic                  sw_on,
  // boost stage
  output logic                       boost_enable,
  output logic                       switch_cycle_kill,
  output logic [3:0]                 ilim_code_r,
  output logic                       switch_node_inject,
  // disconnect switch gate
  output logic                       disc_sink_30ua,
  output logic                       disc_off_r,
  // channels
  output logic [NCH-1:0]             chan_on,
  output logic [NCH-1:0]             channel_open_detect,
  output logic [NCH-1:0]             channel_short_detect,
  output logic [NCH-1:0]             chan_good,
  // status
  output led_sup_pkg::phase_e        phase_r
);
  ////////////////////////////////////////////////////////////////////////////
  // enable filter and shutdown timer
  // counted in clocks
  logic [22:0] low_cnt_r;
  logic [15:0] hi_cnt_r;
  logic        dim_timeout;
  logic        en_pulse_ok;
  logic        ovp_seen_r;
  logic        ovp_drop;
  logic        lx_fail;
  logic [15:0] step_cnt_r;
  logic [NCH-1:0] dis_w;

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      low_cnt_r <= '0;
    else if (enable_dimming_input)
      low_cnt_r <= '0;
    else if (low_cnt_r != 23'(DIM_OFF_CYC))
      low_cnt_r <= low_cnt_r + 23'h000001;
  assign dim_timeout = (low_cnt_r == 23'(DIM_OFF_CYC));

  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      hi_cnt_r <= '0;
    else if (!enable_dimming_input)
      hi_cnt_r <= '0;
    else if (hi_cnt_r != 16'(led_sup_pkg::ENABLE_CYC))
      hi_cnt_r <= hi_cnt_r + 16'h0001;
  assign en_pulse_ok = (hi_cnt_r == 16'(led_sup_pkg::ENABLE_CYC));

  ////////////////////////////////////////////////////////////////////////////
  // disconnect protection detectors
  // switch node must recover whenever switch is off in run
  assign lx_fail = (phase_r == led_sup_pkg::ST_RUN) && !sw_on && !glob_cmp.sw_above_1v2;

  // rise then fall of ovp sense; re-armed on every restart, else a old drop trips again
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      ovp_seen_r <= 1'b0;
    else if (phase_r == led_sup_pkg::ST_OFF || phase_r == led_sup_pkg::ST_WAITEN)
      ovp_seen_r <= 1'b0;
    else if (glob_cmp.ovp_above_20)
      ovp_seen_r <= 1'b1;
  assign ovp_drop = ovp_seen_r && !glob_cmp.ovp_above_20;

  ////////////////////////////////////////////////////////////////////////////
  // phase sequencer
  // undervoltage resets; start-up and trips
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      phase_r <= led_sup_pkg::ST_OFF;
    else if (glob_cmp.input_undervoltage_lockout)
      phase_r <= led_sup_pkg::ST_OFF;
    else
      case (phase_r)
        led_sup_pkg::ST_OFF:
          phase_r <= led_sup_pkg::ST_WAITEN;
        led_sup_pkg::ST_WAITEN:
          if (en_pulse_ok)
            phase_r <= led_sup_pkg::ST_PRECHK;
        led_sup_pkg::ST_PRECHK:
          if (dim_timeout)
            phase_r <= led_sup_pkg::ST_WAITEN;
          else if (glob_cmp.sw_above_1v2)
            phase_r <= led_sup_pkg::ST_INRUSH;
        led_sup_pkg::ST_INRUSH:
          if (dim_timeout)
            phase_r <= led_sup_pkg::ST_WAITEN;
          else if (glob_cmp.disc_full_on)
            phase_r <= led_sup_pkg::ST_RUN;
        led_sup_pkg::ST_RUN:
          if (dim_timeout)
            phase_r <= led_sup_pkg::ST_WAITEN;
          else if (lx_fail || ovp_drop || glob_cmp.in_overcurrent)
            phase_r <= led_sup_pkg::ST_TRIP;
        led_sup_pkg::ST_TRIP:
          if (dim_timeout)
            phase_r <= led_sup_pkg::ST_WAITEN;
        default:
          phase_r <= led_sup_pkg::ST_OFF;
      endcase

  // disconnect opened at once on a switch node or ovp drop trip, not on overcurrent
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
      disc_off_r <= 1'b0;
    else if (phase_r == led_sup_pkg::ST_WAITEN || phase_r == led_sup_pkg::ST_OFF)
      disc_off_r <= 1'b0;
    else if (lx_fail || ovp_drop)
      disc_off_r <= 1'b1;

  // gate sink in inrush and run only, off in precheck and trip
  assign disc_sink_30ua = (phase_r == led_sup_pkg::ST_INRUSH)
                        || (phase_r == led_sup_pkg::ST_RUN);
  assign switch_node_inject = (phase_r == led_sup_pkg::ST_PRECHK);
  assign boost_enable = (phase_r == led_sup_pkg::ST_RUN);
  assign switch_cycle_kill = boost_enable && glob_cmp.sw_over_ilim;

  ////////////////////////////////////////////////////////////////////////////
  // soft-start current limit
  // eight levels, seven equal rises over 1ms
  always_ff @(posedge ref_clk or posedge rst)
    if (rst)
    begin
      ilim_code_r <= led_sup_pkg::ILIM_FIRST;
      step_cnt_r  <= '0;
    end
    else if (phase_r != led_sup_pkg::ST_RUN)
    begin
      ilim_code_r <= led_sup_pkg::ILIM_FIRST;
      step_cnt_r  <= '0;
    end
    else if (ilim_code_r != led_sup_pkg::ILIM_FINAL)
    begin
      if (step_cnt_r == 16'(SOFT_STEP - 1))
      begin
        step_cnt_r  <= '0;
        ilim_code_r <= ilim_code_r + 4'h1;
      end
      else
        step_cnt_r <= step_cnt_r + 16'h0001;
    end

  ////////////////////////////////////////////////////////////////////////////
  // channels
  genvar g;
  generate
    for (g = 0; g < NCH; g++)
    begin : g_ch
      chan_monitor #(
        .TO_CYC     (OPEN_TO),
        .HOT_TO_CYC (OPEN_HOT_TO)
      ) u_mon (
        .ref_clk    (ref_clk),
        .rst        (rst),
        .active     (boost_enable),
        .stable     (glob_cmp.stable),
        .hot        (glob_cmp.otp_lower),
        .ovp_limit  (glob_cmp.ovp_limit),
        .above_75   (chan_cmp.above_75[g]),
        .below_50   (chan_cmp.below_50[g]),
        .above_8v   (chan_cmp.above_8v[g]),
        .good_r     (chan_good[g]),
        .open_r     (channel_open_detect[g]),
        .disabled_r (dis_w[g])
      );
      assign channel_short_detect[g] = dis_w[g] && !channel_open_detect[g];
      assign chan_on[g] = boost_enable && enable_dimming_input && !dis_w[g];
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // checks
  property p_dim_off;
    @(posedge ref_clk) disable iff (rst)
      (phase_r == led_sup_pkg::ST_RUN && dim_timeout && !glob_cmp.input_undervoltage_lockout)
      |=> phase_r == led_sup_pkg::ST_WAITEN;
  endproperty
  a_dim_off: assert property (p_dim_off) else $error("no shutdown after dim timeout");

  property p_gate;
    @(posedge ref_clk) disable iff (rst)
      !enable_dimming_input |-> chan_on == '0;
  endproperty
  a_gate: assert property (p_gate) else $error("channel on while dimming low");

  property p_switch_after_inrush;
    @(posedge ref_clk) disable iff (rst)
      $rose(boost_enable) |-> $past(glob_cmp.disc_full_on);
  endproperty
  a_switch_after_inrush: assert property (p_switch_after_inrush) else $error("early switch");

  property p_kill;
    @(posedge ref_clk) disable iff (rst)
      (boost_enable && glob_cmp.sw_over_ilim) |-> switch_cycle_kill;
  endproperty
  a_kill: assert property (p_kill) else $error("overcurrent cycle not ended");

  property p_soft_start;
    @(posedge ref_clk) disable iff (rst)
      $rose(boost_enable) |-> ilim_code_r == led_sup_pkg::ILIM_FIRST;
  endproperty
  a_soft_start: assert property (p_soft_start) else $error("soft start not at first step");

  property p_soft_step;
    @(posedge ref_clk) disable iff (rst)
      (boost_enable && $changed(ilim_code_r)) |-> ilim_code_r == $past(ilim_code_r) + 4'h1;
  endproperty
  a_soft_step: assert property (p_soft_step) else $error("limit step not one unit");

  property p_input_undervoltage_lockout;
    @(posedge ref_clk) disable iff (rst)
      glob_cmp.input_undervoltage_lockout |=> !boost_enable;
  endproperty
  a_input_undervoltage_lockout: assert property (p_input_undervoltage_lockout) else $error("switching during undervoltage");

  property p_lx_trip;
    @(posedge ref_clk) disable iff (rst)
      lx_fail && !glob_cmp.input_undervoltage_lockout |=> disc_off_r;
  endproperty
  a_lx_trip: assert property (p_lx_trip) else $error("disconnect not opened");

  property p_ovp_trip;
    @(posedge ref_clk) disable iff (rst)
      (phase_r == led_sup_pkg::ST_RUN && ovp_drop && !glob_cmp.input_undervoltage_lockout) |=> disc_off_r;
  endproperty
  a_ovp_trip: assert property (p_ovp_trip) else $error("ovp drop not tripped");

  property p_precheck;
    @(posedge ref_clk) disable iff (rst)
      $rose(phase_r == led_sup_pkg::ST_INRUSH) |-> $past(glob_cmp.sw_above_1v2);
  endproperty
  a_precheck: assert property (p_precheck) else $error("started without switch node");

  property p_dim_hold;
    @(posedge ref_clk) disable iff (rst)
      (phase_r == led_sup_pkg::ST_RUN && !dim_timeout) |=> phase_r != led_sup_pkg::ST_WAITEN;
  endproperty
  a_dim_hold: assert property (p_dim_hold) else $error("shutdown before dim timeout");

  property p_en_filter;
    @(posedge ref_clk) disable iff (rst)
      (phase_r == led_sup_pkg::ST_WAITEN && !en_pulse_ok)
      |=> phase_r != led_sup_pkg::ST_PRECHK;
  endproperty
  a_en_filter: assert property (p_en_filter) else $error("short enable taken");

  property p_oc_trip;
    @(posedge ref_clk) disable iff (rst)
      (phase_r == led_sup_pkg::ST_RUN && glob_cmp.in_overcurrent && !dim_timeout
       && !glob_cmp.input_undervoltage_lockout) |=> (phase_r == led_sup_pkg::ST_TRIP && chan_on == '0);
  endproperty
  a_oc_trip: assert property (p_oc_trip) else $error("overcurrent left channels on");

  property p_lx_wait;
    @(posedge ref_clk) disable iff (rst)
      (phase_r == led_sup_pkg::ST_PRECHK && !glob_cmp.sw_above_1v2)
      |=> phase_r != led_sup_pkg::ST_INRUSH;
  endproperty
  a_lx_wait: assert property (p_lx_wait) else $error("inrush without switch node");

  property p_sink;
    @(posedge ref_clk) disable iff (rst)
      (phase_r == led_sup_pkg::ST_INRUSH) |-> disc_sink_30ua && !switch_node_inject;
  endproperty
  a_sink: assert property (p_sink) else $error("no gate sink in inrush");

  property p_disc_hold;
    @(posedge ref_clk) disable iff (rst)
      (disc_off_r && phase_r != led_sup_pkg::ST_WAITEN && phase_r != led_sup_pkg::ST_OFF)
      |=> disc_off_r;
  endproperty
  a_disc_hold: assert property (p_disc_hold) else $error("disconnect released early");

  property p_rearm;
    @(posedge ref_clk) disable iff (rst)
      (phase_r == led_sup_pkg::ST_WAITEN) |=> !disc_off_r && !ovp_seen_r;
  endproperty
  a_rearm: assert property (p_rearm) else $error("trip state kept across restart");

  property p_ilim_idle;
    @(posedge ref_clk) disable iff (rst)
      !boost_enable |=> ilim_code_r == led_sup_pkg::ILIM_FIRST;
  endproperty
  a_ilim_idle: assert property (p_ilim_idle) else $error("limit not back at first step");

  property p_step_hold;
    @(posedge ref_clk) disable iff (rst)
      (boost_enable && step_cnt_r != 16'(SOFT_STEP - 1)) |=> $stable(ilim_code_r);
  endproperty
  a_step_hold: assert property (p_step_hold) else $error("limit stepped between ticks");

  property p_chan_idle;
    @(posedge ref_clk) disable iff (rst)
      !boost_enable |=> chan_good == '0 && channel_open_detect == '0;
  endproperty
  a_chan_idle: assert property (p_chan_idle) else $error("channel state kept outside run");

  c_run:  cover property (@(posedge ref_clk) disable iff (rst) ilim_code_r == led_sup_pkg::ILIM_FINAL);
  c_trip: cover property (@(posedge ref_clk) disable iff (rst) disc_off_r);
  c_open: cover property (@(posedge ref_clk) disable iff (rst) channel_open_detect != '0);
  c_lx:   cover property (@(posedge ref_clk) disable iff (rst) lx_fail);
  c_oc:   cover property (@(posedge ref_clk) disable iff (rst)
                          phase_r == led_sup_pkg::ST_TRIP);
endmodule
`default_nettype wire

// ---- testbench/dim_source.sv ----
// behavioural dimming and enable source driving the supervisor
`timescale 1ns/1ns
`default_nettype none
module dim_source (
  // clock and reset
  input  wire logic        ref_clk,
  input  wire logic        rst,
  // control: 0 low, 1 steady high, 2 pwm
  input  wire logic [1:0]  mode,
  input  wire logic [15:0] on_cyc,
  input  wire logic [15:0] off_cyc,
  // dimming line
  output logic             dim_out
);
  logic [15:0] cnt_r;

  always_ff @(posedge ref_clk or posedge rst)
  begin
    if (rst)
    begin
      cnt_r   <= 16'h0000;
      dim_out <= 1'b0;
    end
    else if (mode != 2'h2)
    begin
      cnt_r   <= 16'h0000;
      dim_out <= mode[0];
    end
    else if (cnt_r >= (dim_out ? on_cyc : off_cyc) - 16'h0001)
    begin
      cnt_r   <= 16'h0000;
      dim_out <= ~dim_out;
    end
    else
    begin
      cnt_r <= cnt_r + 16'h0001;
    end
  end
endmodule
`default_nettype wire

// ---- testbench/led_driver_fault_supervisor_test.sv ----
// self-checking bench for the led fault supervisor
`timescale 1ns/1ns
`default_nettype none
module led_driver_fault_supervisor_test;
  // shortened counts keep the run small
  localparam int unsigned DOFF = 200;
  localparam int unsigned STEP = 4;
  localparam int unsigned OTO  = 100;
  localparam int unsigned HTO  = 20;

  logic                   ref_clk;
  logic                   rst;
  logic                   dim;
  logic [1:0]             mode;
  led_sup_pkg::chan_cmp_s cc;
  led_sup_pkg::glob_cmp_s gc;
  logic                   sw_on;
  logic                   boost;
  logic                   kill;
  logic [3:0]             ilim;
  logic                   inject;
  logic                   sink;
  logic                   disc_off;
  logic [7:0]             chan_on;
  logic [7:0]             open;
  logic [7:0]             short;
  logic [7:0]             good;
  led_sup_pkg::phase_e    ph;
  int                     n_fail;
  int                     num_checks;

  dim_source src (.ref_clk(ref_clk), .rst(rst), .mode(mode), .on_cyc(16'h000A),
                  .off_cyc(16'h000A), .dim_out(dim));

  led_driver_fault_supervisor #(.DIM_OFF_CYC(DOFF), .SOFT_STEP(STEP), .OPEN_TO(OTO),
                                .OPEN_HOT_TO(HTO)) dut (
    .ref_clk(ref_clk), .rst(rst), .enable_dimming_input(dim), .chan_cmp(cc),
    .glob_cmp(gc), .sw_on(sw_on), .boost_enable(boost), .switch_cycle_kill(kill),
    .ilim_code_r(ilim), .switch_node_inject(inject), .disc_sink_30ua(sink),
    .disc_off_r(disc_off), .chan_on(chan_on), .channel_open_detect(open),
    .channel_short_detect(short), .chan_good(good), .phase_r(ph));

  initial
  begin
    ref_clk = 1'b0;
    forever #25 ref_clk = ~ref_clk;
  end

  ////////////////////////////////////////////////////////////////////////////
  task end_sim;
    if (n_fail == 0 && num_checks > 0)
      $display("Regression OK");
    else
      $display("Regression broken");
    $finish;
  endtask

  task tick(input int n);
    repeat (n) @(posedge ref_clk);
    #5;
  endtask

  task chk(input logic [7:0] got, input logic [7:0] exp, input string msg);
    num_checks++;
    if (got !== exp)
    begin
      n_fail++;
      $display("unexpected %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask

  task chk_ph(input led_sup_pkg::phase_e exp, input string msg);
    chk({5'h00, ph}, {5'h00, exp}, msg);
  endtask

  // bounded wait; running out ends the run
  task wait_ph(input led_sup_pkg::phase_e exp, input int max);
    int i;
    for (i = 0; i < max && ph !== exp; i++)
      tick(1);
    if (ph !== exp)
    begin
      chk_ph(exp, "phase wait timed out");
      end_sim;
    end
  endtask

  ////////////////////////////////////////////////////////////////////////////
  task bring_up;
    gc = '0;
    cc = '0;
    mode = 2'h1;
    tick(700);
    chk_ph(led_sup_pkg::ST_WAITEN, "enable accepted early");
    wait_ph(led_sup_pkg::ST_PRECHK, 200);
    chk({5'h00, inject, sink, boost}, 8'h04, "precheck outputs");
    tick(20);
    chk_ph(led_sup_pkg::ST_PRECHK, "left precheck below 1.2V");
    gc.sw_above_1v2 = 1'b1;
    wait_ph(led_sup_pkg::ST_INRUSH, 3);
    tick(20);
    chk({5'h00, inject, sink, boost}, 8'h02, "inrush outputs");
    gc.disc_full_on = 1'b1;
    wait_ph(led_sup_pkg::ST_RUN, 3);
    chk({7'h00, boost}, 8'h01, "boost after inrush");
    chk({7'h00, disc_off}, 8'h00, "disconnect held after restart");
  endtask

  task drop;
    mode = 2'h0;
    wait_ph(led_sup_pkg::ST_WAITEN, DOFF + 50);
  endtask

  task t_enable;
    mode = 2'h1;
    tick(100);
    mode = 2'h0;
    tick(10);
    chk_ph(led_sup_pkg::ST_WAITEN, "short pulse enabled");
    bring_up;
  endtask

  task t_soft;
    int k;
    for (k = 0; k < 8; k++)
    begin
      tick(k == 0 ? 2 : STEP);
      chk({4'h0, ilim}, 8'(k + 1), "soft-start limit");
    end
    tick(STEP * 2);
    chk({4'h0, ilim}, 8'h08, "final limit");
    gc.sw_over_ilim = 1'b1;
    tick(1);
    chk({7'h00, kill}, 8'h01, "cycle kill");
    gc.sw_over_ilim = 1'b0;
    tick(1);
    chk({7'h00, kill}, 8'h00, "cycle kill idle");
  endtask

  task t_dim;
    int k;
    mode = 2'h2;
    for (k = 0; k < 40; k++)
    begin
      tick(1);
      chk(chan_on, {8{dim}}, "gating by dimming");
    end
    mode = 2'h0;
    tick(DOFF - 20);
    chk_ph(led_sup_pkg::ST_RUN, "early shutdown");
    tick(40);
    chk_ph(led_sup_pkg::ST_WAITEN, "no shutdown");
  endtask

  task t_chan;
    cc.above_75 = 8'h0F;
    tick(3);
    chk(good, 8'h0F, "good marking");
    cc.below_50 = 8'h01;
    tick(5);
    chk(open, 8'h00, "open while unstable");
    gc.stable = 1'b1;
    tick(3);
    chk(open, 8'h01, "open after drop");
    tick(OTO / 2);
    chk(chan_on, 8'hFF, "early disable");
    tick(OTO / 2 + 5);
    chk(chan_on, 8'hFE, "open timeout");
    cc.above_8v = 8'h02;
    tick(3);
    chk(short, 8'h02, "short detect");
    chk(chan_on, 8'hFC, "short disable");
    gc.ovp_limit = 1'b1;
    gc.otp_lower = 1'b1;
    tick(2);
    chk(open, 8'hF1, "non-good open");
    tick(HTO / 2);
    chk(chan_on, 8'hFC, "hot early disable");
    tick(HTO / 2 + 5);
    chk(chan_on, 8'h0C, "hot timeout");
  endtask

  task t_faults;
    gc.in_overcurrent = 1'b1;
    tick(3);
    chk_ph(led_sup_pkg::ST_TRIP, "overcurrent trip");
    chk(chan_on, 8'h00, "channels after trip");
    drop;
    bring_up;
    sw_on = 1'b1;
    gc.sw_above_1v2 = 1'b0;
    tick(3);
    chk_ph(led_sup_pkg::ST_RUN, "trip while switch on");
    sw_on = 1'b0;
    tick(3);
    chk({7'h00, disc_off}, 8'h01, "switch node low");
    drop;
    bring_up;
    gc.ovp_above_20 = 1'b1;
    tick(3);
    chk_ph(led_sup_pkg::ST_RUN, "ovp rise alone");
    gc.ovp_above_20 = 1'b0;
    tick(3);
    chk({7'h00, disc_off}, 8'h01, "ovp fall");
    drop;
    bring_up;
    gc.input_undervoltage_lockout = 1'b1;
    tick(3);
    chk_ph(led_sup_pkg::ST_OFF, "undervoltage reset");
    chk({7'h00, boost}, 8'h00, "boost in lockout");
    gc.input_undervoltage_lockout = 1'b0;
    tick(1);
    chk_ph(led_sup_pkg::ST_WAITEN, "restart");
    wait_ph(led_sup_pkg::ST_RUN, 5);
    chk_ph(led_sup_pkg::ST_RUN, "restart to run");
  endtask

  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    n_fail = 0;
    num_checks = 0;
    rst = 1'b1;
    mode = 2'h0;
    cc = '0;
    gc = '0;
    sw_on = 1'b0;
    repeat (16) @(posedge ref_clk);
    #5 rst = 1'b0;
    tick(2);
    chk_ph(led_sup_pkg::ST_WAITEN, "phase after reset");
    t_enable;
    t_soft;
    t_dim;
    bring_up;
    t_chan;
    drop;
    bring_up;
    t_faults;
    end_sim;
  end
endmodule
`default_nettype wire
